/* File: verilog/nfh_pkg.sv */
// How it works
// RULE1: Feature commands only while all dies idle.
// RULE2: Feature-read mode holds until next command.
// RULE3: Target busy after feature address byte.
// RULE4: After status polling, send read-mode command.
// RULE5: No addressed status around feature data.
// RULE6: Read four subfeature bytes in order.
// RULE7: Timing mode in bits 2:0, rest zero.
// RULE8: Timing mode resets to mode 0.
// RULE9: Drive strength in bits 1:0, rest zero.
// RULE10: Drive strength resets to full.
// RULE11: Busy pull-down uses same encoding, full default.
// RULE12: Each die owns an 8-bit status byte.
// RULE13: Status commands make die output status.
// RULE14: Status output tracks changes while strobed.
// RULE15: After fetch polling, read-mode restores data.
// RULE16: Plain status answers last die, even busy.
// RULE17: Multi-die status needs the addressed command.
// RULE18: Bit 7 low means write protected.
// RULE19: Bits 6,5 high ready; 4:2 zero.
// RULE20: Cache mode bit 6 drives busy pin.
// RULE21: Bit 5 low while array programs.
// RULE22: Bit 0 current fail, bit 1 previous.
// RULE23: Feature write takes four bytes, then busy.
package nfh_pkg;
    // Pin timing, printed figures and derived cycle counts
    localparam int CLK_PERIOD_NS = 40;
    localparam int T_PULSE_NS    = 25;
    localparam int T_WB_NS       = 100;
    localparam int T_WHR_NS      = 60;
    localparam int T_ADL_NS      = 70;
    localparam int SYNC_CYC      = 2;
    localparam int PULSE_CYC = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WB_CYC    = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WHR_CYC   = (T_WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADL_CYC   = (T_ADL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Command codes
    localparam logic [7:0] CMD_GET_FEAT   = 8'hEE;
    localparam logic [7:0] CMD_SET_FEAT   = 8'hEF;
    localparam logic [7:0] CMD_STATUS     = 8'h70;
    localparam logic [7:0] CMD_STATUS_SEL = 8'h78;
    localparam logic [7:0] CMD_READ_MODE  = 8'h00;
    // Device feature map and power-on values
    localparam logic [7:0]  FEAT_INTERFACE_SPEED = 8'h01;
    localparam logic [7:0]  FEAT_OUTPUT_DRIVER   = 8'h80;
    localparam logic [7:0]  FEAT_BUSY_PULLDOWN   = 8'h81;
    localparam logic [31:0] FEAT_RESET           = 32'h0000_0000;
    localparam int SUBFEAT_BYTES = 4;
    localparam int ROW_CYCLES    = 3;
    // Die condition byte fields
    localparam int SR_WP_BIT         = 7;
    localparam int SR_READY_BIT      = 6;
    localparam int SR_ARRAY_IDLE_BIT = 5;
    localparam int SR_PRIOR_FAIL_BIT = 1;
    localparam int SR_FAIL_BIT       = 0;
    // Controller registers on APB
    localparam logic [7:0] REG_CMD   = 8'h00;
    localparam logic [7:0] REG_CFG   = 8'h04;
    localparam logic [7:0] REG_PARAM = 8'h08;
    localparam logic [7:0] REG_ROW   = 8'h0C;
    localparam logic [7:0] REG_STAT  = 8'h10;
    localparam int CFG_MULTI_BIT   = 8;
    localparam int CFG_WP_OFF_BIT  = 9;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_REFUSE_BIT = 1;
    localparam int STAT_RB_BIT     = 2;
    typedef enum logic [1:0] {OP_GET_FEAT, OP_SET_FEAT, OP_STATUS} nfh_op_type;
    typedef enum logic [1:0] {CYC_CMD, CYC_ADDR, CYC_DIN, CYC_DOUT} nfh_kind_type;
    typedef struct packed {
        nfh_kind_type kind;
        logic [7:0]   data;
    } nfh_cyc_type;
endpackage

/* File: verilog/nfh_pin_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module nfh_pin_seq import nfh_pkg::*; #(
    parameter int PULSE = PULSE_CYC,
    parameter int HOLD  = PULSE_CYC + SYNC_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Cycle request and answer
    input  wire logic        start,
    input  wire nfh_cyc_type cyc,
    input  wire logic [7:0]  io_sync,
    output logic             done,
    output logic [7:0]       rdata,
    // Pin drive
    output logic             cle,
    output logic             ale,
    output logic             we_n,
    output logic             re_n,
    output logic [7:0]       io_out,
    output logic             io_oe
);
    typedef enum logic [1:0] {Q_IDLE, Q_SETUP, Q_LOW, Q_HIGH} nfh_q_type;
    nfh_q_type    state_reg;
    logic         rd_reg;
    logic [3:0]   cnt_reg;

    generate
        if (PULSE < 1 || HOLD > 15 || HOLD < PULSE) begin : g_bad
            $error("nfh_pin_seq: pulse counts out of range");
        end
    endgenerate

    // One bus cycle: setup, strobe low, strobe high hold
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= Q_IDLE;
            rd_reg    <= 1'b0;
            cnt_reg   <= 4'h0;
            done      <= 1'b0;
            rdata     <= 8'h00;
            cle       <= 1'b0;
            ale       <= 1'b0;
            we_n      <= 1'b1;
            re_n      <= 1'b1;
            io_out    <= 8'h00;
            io_oe     <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state_reg)
                Q_IDLE: if (start) begin
                    cle       <= (cyc.kind == CYC_CMD);
                    ale       <= (cyc.kind == CYC_ADDR);
                    io_out    <= cyc.data;
                    io_oe     <= (cyc.kind != CYC_DOUT);
                    rd_reg    <= (cyc.kind == CYC_DOUT);
                    state_reg <= Q_SETUP;
                end
                Q_SETUP: begin
                    // Latches hold before the strobe falls
                    if (rd_reg) begin
                        re_n    <= 1'b0;
                        cnt_reg <= 4'(HOLD);
                    end else begin
                        we_n    <= 1'b0;
                        cnt_reg <= 4'(PULSE);
                    end
                    state_reg <= Q_LOW;
                end
                Q_LOW: if (cnt_reg == 4'h1) begin
                    // Read low stretched to cover the input synchroniser
                    we_n    <= 1'b1;
                    re_n    <= 1'b1;
                    if (rd_reg) begin
                        rdata <= io_sync;
                    end
                    cnt_reg   <= 4'(PULSE);
                    state_reg <= Q_HIGH;
                end else begin
                    cnt_reg <= cnt_reg - 4'h1;
                end
                Q_HIGH: if (cnt_reg == 4'h1) begin
                    cle       <= 1'b0;
                    ale       <= 1'b0;
                    io_oe     <= 1'b0;
                    done      <= 1'b1;
                    state_reg <= Q_IDLE;
                end else begin
                    cnt_reg <= cnt_reg - 4'h1;
                end
            endcase
        end
    end

    property p_no_contention;
        @(posedge clk) disable iff (!rst_n) !re_n |-> !io_oe;
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("drive during read");

    property p_cycle_bound;
        @(posedge clk) disable iff (!rst_n)
            (start && state_reg == Q_IDLE) |-> ##[3:20] done;
    endproperty
    a_cycle_bound: assert property (p_cycle_bound) else $error("bus cycle never ended");
endmodule // nfh_pin_seq
`default_nettype wire

/* File: verilog/nfh_ctrl.sv */
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module nfh_ctrl import nfh_pkg::*; (
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RESETN,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // NAND pins
    output logic             NAND_CE_N,
    output logic             NAND_CLE,
    output logic             NAND_ALE,
    output logic             NAND_WE_N,
    output logic             NAND_RE_N,
    output logic             NAND_WP_N,
    output logic      [7:0]  NAND_IO_OUT,
    output logic             NAND_IO_OE,
    input  wire logic [7:0]  NAND_IO_IN,
    input  wire logic        NAND_RB_N
);
    typedef enum logic [3:0] {
        S_IDLE, S_CMD, S_ADDR, S_DIN, S_WAIT, S_PCMD, S_PRD, S_MODE, S_DOUT, S_STRD, S_DONE
    } nfh_state_type;

    nfh_state_type state_reg, after_reg;
    nfh_op_type    op_reg;
    nfh_cyc_type   cyc_reg, cyc_next;
    logic [3:0]    wait_reg;
    logic [1:0]    cnt_reg;
    logic [1:0]    rb_sync_reg;
    logic [7:0]    io_meta_reg, io_sync_reg;
    logic [31:0]   param_reg, cfg_reg;
    logic [23:0]   row_reg;
    logic [7:0]    die_stat_reg;
    logic          refuse_reg, launch_reg, waiting_reg, want;
    logic          seq_done;
    logic [7:0]    seq_rdata;
    logic          busy, rb_ready, acc, wr, start_req, start_ok;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == REG_CMD) || (a == REG_CFG) || (a == REG_PARAM) ||
                 (a == REG_ROW) || (a == REG_STAT);
    endfunction

    // Pin inputs cross into the clock domain
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rb_sync_reg <= 2'b00;
            io_meta_reg <= 8'h00;
            io_sync_reg <= 8'h00;
        end else begin
            rb_sync_reg <= {rb_sync_reg[0], NAND_RB_N};
            io_meta_reg <= NAND_IO_IN;
            io_sync_reg <= io_meta_reg;
        end
    end

    assign busy      = (state_reg != S_IDLE);
    assign rb_ready  = rb_sync_reg[1];
    assign acc       = PSEL && PENABLE && PREADY;
    assign wr        = acc && PWRITE && mapped(PADDR);
    assign start_req = wr && (PADDR == REG_CMD);
    // Feature commands are refused unless every die is idle; plain status goes even when a die is busy
    assign start_ok  = start_req && !busy && (PWDATA[1:0] != 2'b11) &&
                       ((PWDATA[1:0] == 2'(OP_STATUS)) || rb_ready); // see RULE1 see RULE16

    // APB answer, one wait-free access phase
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !mapped(PADDR);
            if (PSEL && !PENABLE && !PWRITE) begin
                unique case (PADDR)
                    REG_CMD:   PRDATA <= {30'h0, op_reg};
                    REG_CFG:   PRDATA <= cfg_reg;
                    REG_PARAM: PRDATA <= param_reg;
                    REG_ROW:   PRDATA <= {8'h00, row_reg};
                    REG_STAT:  PRDATA <= {16'h0000, die_stat_reg, 5'h00, rb_ready,
                                          refuse_reg, busy}; // see RULE12
                    default:   PRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Configuration, row address and refusal flag
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            cfg_reg    <= FEAT_RESET;
            row_reg    <= 24'h000000;
            refuse_reg <= 1'b0;
            NAND_WP_N  <= 1'b0;
        end else begin
            if (wr && PADDR == REG_CFG) begin
                cfg_reg <= PWDATA;
            end
            if (wr && PADDR == REG_ROW) begin
                row_reg <= PWDATA[23:0];
            end
            NAND_WP_N <= cfg_reg[CFG_WP_OFF_BIT];
            // A new refusal wins over a clear in the same cycle
            if (start_req && !start_ok) begin
                refuse_reg <= 1'b1;
            end else if (wr && PADDR == REG_STAT && PWDATA[STAT_REFUSE_BIT]) begin
                refuse_reg <= 1'b0;
            end
        end
    end

    // Subfeature bytes: written by software, filled by feature reads
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            param_reg    <= FEAT_RESET;
            die_stat_reg <= 8'h00;
        end else begin
            if (wr && PADDR == REG_PARAM && !busy) begin
                param_reg <= PWDATA;
            end
            if (seq_done && state_reg == S_DOUT) begin
                param_reg[{cnt_reg, 3'b000} +: 8] <= seq_rdata; // see RULE6 see RULE7 see RULE9
            end
            if (seq_done && (state_reg == S_PRD || state_reg == S_STRD)) begin
                die_stat_reg <= seq_rdata; // see RULE13 see RULE18 see RULE19 see RULE22
            end
        end
    end

    // Byte for the current bus cycle
    always_comb begin
        want          = 1'b1;
        cyc_next.kind = CYC_DOUT;
        cyc_next.data = 8'h00;
        unique case (state_reg)
            S_CMD: begin
                cyc_next.kind = CYC_CMD;
                unique case (op_reg)
                    OP_GET_FEAT: cyc_next.data = CMD_GET_FEAT;
                    OP_SET_FEAT: cyc_next.data = CMD_SET_FEAT; // see RULE23
                    default: cyc_next.data = cfg_reg[CFG_MULTI_BIT] ? CMD_STATUS_SEL
                                                                    : CMD_STATUS; // see RULE17
                endcase
            end
            S_ADDR: begin
                cyc_next.kind = CYC_ADDR;
                cyc_next.data = (op_reg == OP_STATUS) ? row_reg[{cnt_reg, 3'b000} +: 8]
                                                      : cfg_reg[7:0];
            end
            S_DIN: begin
                cyc_next.kind = CYC_DIN;
                cyc_next.data = param_reg[{cnt_reg, 3'b000} +: 8];
            end
            S_PCMD: begin
                cyc_next.kind = CYC_CMD;
                cyc_next.data = CMD_STATUS; // see RULE5
            end
            S_MODE: begin
                cyc_next.kind = CYC_CMD;
                cyc_next.data = CMD_READ_MODE; // see RULE4 see RULE15
            end
            S_PRD, S_DOUT, S_STRD: cyc_next.kind = CYC_DOUT;
            default: want = 1'b0;
        endcase
    end

    // Hand one cycle at a time to the pin sequencer
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            launch_reg  <= 1'b0;
            waiting_reg <= 1'b0;
            cyc_reg     <= '0;
        end else begin
            launch_reg <= 1'b0;
            if (want && !waiting_reg) begin
                launch_reg  <= 1'b1;
                waiting_reg <= 1'b1;
                cyc_reg     <= cyc_next;
            end else if (seq_done) begin
                waiting_reg <= 1'b0;
            end
        end
    end

    // Operation sequence
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg <= S_IDLE;
            after_reg <= S_IDLE;
            op_reg    <= OP_STATUS;
            wait_reg  <= 4'h0;
            cnt_reg   <= 2'b00;
            NAND_CE_N <= 1'b1;
        end else begin
            unique case (state_reg)
                S_IDLE: if (start_ok) begin
                    op_reg    <= nfh_op_type'(PWDATA[1:0]);
                    cnt_reg   <= 2'b00;
                    NAND_CE_N <= 1'b0;
                    state_reg <= S_CMD;
                end
                S_CMD: if (seq_done) begin
                    cnt_reg   <= 2'b00;
                    state_reg <= (op_reg == OP_STATUS && !cfg_reg[CFG_MULTI_BIT]) ? S_STRD
                                                                                    : S_ADDR;
                end
                S_ADDR: if (seq_done) begin
                    cnt_reg   <= cnt_reg + 2'b01;
                    state_reg <= S_WAIT;
                    if (op_reg == OP_GET_FEAT) begin
                        wait_reg  <= 4'(WB_CYC); // see RULE3
                        after_reg <= S_PCMD;
                    end else if (op_reg == OP_SET_FEAT) begin
                        wait_reg  <= 4'(ADL_CYC);
                        after_reg <= S_DIN;
                        cnt_reg   <= 2'b00;
                    end else if (cnt_reg == 2'(ROW_CYCLES - 1)) begin
                        wait_reg  <= 4'(WHR_CYC);
                        after_reg <= S_STRD;
                    end else begin
                        state_reg <= S_ADDR;
                    end
                end
                S_DIN: if (seq_done) begin
                    cnt_reg <= cnt_reg + 2'b01;
                    if (cnt_reg == 2'(SUBFEAT_BYTES - 1)) begin
                        wait_reg  <= 4'(WB_CYC); // see RULE23
                        after_reg <= S_PCMD;
                        state_reg <= S_WAIT;
                    end
                end
                S_WAIT: if (wait_reg <= 4'h1) begin
                    state_reg <= after_reg;
                end else begin
                    wait_reg <= wait_reg - 4'h1;
                end
                S_PCMD: if (seq_done) begin
                    wait_reg  <= 4'(WHR_CYC);
                    after_reg <= S_PRD;
                    state_reg <= S_WAIT;
                end
                S_PRD: if (seq_done && seq_rdata[SR_READY_BIT]) begin // see RULE14
                    state_reg <= (op_reg == OP_GET_FEAT) ? S_MODE : S_DONE; // see RULE4
                end
                S_MODE: if (seq_done) begin
                    cnt_reg   <= 2'b00;
                    wait_reg  <= 4'(WHR_CYC);
                    after_reg <= S_DOUT;
                    state_reg <= S_WAIT;
                end
                S_DOUT: if (seq_done) begin
                    cnt_reg <= cnt_reg + 2'b01;
                    if (cnt_reg == 2'(SUBFEAT_BYTES - 1)) begin
                        state_reg <= S_DONE; // see RULE6
                    end
                end
                S_STRD: if (seq_done) begin
                    state_reg <= S_DONE;
                end
                S_DONE: begin
                    NAND_CE_N <= 1'b1;
                    state_reg <= S_IDLE;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    nfh_pin_seq u_seq (
        .clk     (REF_CLK),
        .rst_n   (RESETN),
        .start   (launch_reg),
        .cyc     (cyc_reg),
        .io_sync (io_sync_reg),
        .done    (seq_done),
        .rdata   (seq_rdata),
        .cle     (NAND_CLE),
        .ale     (NAND_ALE),
        .we_n    (NAND_WE_N),
        .re_n    (NAND_RE_N),
        .io_out  (NAND_IO_OUT),
        .io_oe   (NAND_IO_OE)
    );

    property p_feat_idle;
        @(posedge REF_CLK) disable iff (!RESETN)
            ($fell(NAND_CE_N) && op_reg != OP_STATUS) |-> $past(rb_ready);
    endproperty
    a_feat_idle: assert property (p_feat_idle) else $error("feature start while busy"); // see RULE1

    property p_mode_after_poll;
        @(posedge REF_CLK) disable iff (!RESETN)
            (state_reg == S_PRD && seq_done && seq_rdata[SR_READY_BIT] && op_reg == OP_GET_FEAT)
            |=> state_reg == S_MODE ##[1:40] (launch_reg && cyc_reg.data == CMD_READ_MODE);
    endproperty
    a_mode_after_poll: assert property (p_mode_after_poll) else $error("no read mode"); // see RULE4

    property p_no_sel_status;
        @(posedge REF_CLK) disable iff (!RESETN)
            (launch_reg && op_reg != OP_STATUS && cyc_reg.kind == CYC_CMD)
            |-> cyc_reg.data != CMD_STATUS_SEL;
    endproperty
    a_no_sel_status: assert property (p_no_sel_status) else $error("78h in feature op"); // see RULE5

    property p_four_bytes;
        @(posedge REF_CLK) disable iff (!RESETN)
            (state_reg == S_DOUT && seq_done && cnt_reg == 2'b11) |=> state_reg == S_DONE ##1
            (state_reg == S_IDLE && NAND_CE_N);
    endproperty
    a_four_bytes: assert property (p_four_bytes) else $error("feature read length"); // see RULE6

    property p_multi_sel;
        @(posedge REF_CLK) disable iff (!RESETN)
            (launch_reg && state_reg == S_CMD && op_reg == OP_STATUS && cfg_reg[CFG_MULTI_BIT])
            |-> cyc_reg.data == CMD_STATUS_SEL;
    endproperty
    a_multi_sel: assert property (p_multi_sel) else $error("plain status on multi die"); // see RULE17

    property p_setf_poll;
        @(posedge REF_CLK) disable iff (!RESETN)
            (state_reg == S_DIN && seq_done && cnt_reg == 2'b11)
            |=> (state_reg == S_WAIT && after_reg == S_PCMD);
    endproperty
    a_setf_poll: assert property (p_setf_poll) else $error("no busy wait"); // see RULE23

    property p_ce_busy;
        @(posedge REF_CLK) disable iff (!RESETN)
            (NAND_CE_N && !NAND_WE_N) |-> 1'b0;
    endproperty
    a_ce_busy: assert property (p_ce_busy) else $error("strobe without chip enable");
endmodule // nfh_ctrl
`default_nettype wire

/* File: verification/nfh_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module nfh_flash_model import nfh_pkg::*; #(
    parameter int FEAT_NS = 400
) (
    // Strobes and bus from the controller
    input  wire logic       ce_n,
    input  wire logic       cle,
    input  wire logic       ale,
    input  wire logic       we_n,
    input  wire logic       re_n,
    input  wire logic       wp_n,
    input  wire logic [7:0] io_out,
    input  wire logic       io_oe,
    // Answers
    output logic      [7:0] io_in,
    output logic            rb_n
);
    logic [7:0] feat [4];
    logic [7:0] msk [4];
    logic [7:0] cmd, val, last, drive;
    logic [1:0] fa;
    logic       rdy;
    int         n;
    event       arm;
    // Power-on values; slot 3 soaks up reserved addresses
    initial begin
        feat = '{8'h00, 8'h00, 8'h00, 8'h00};
        msk  = '{8'h07, 8'h03, 8'h03, 8'h00};
        rdy = 1'b1;
        cmd = 8'h00;
        fa = 2'd3;
        n = 0;
        last = 8'h00;
    end
    // Latch command, address and data on the write strobe rise
    always @(posedge we_n) if (!ce_n) begin
        if (cle) begin
            if (rdy || (io_out != CMD_GET_FEAT && io_out != CMD_SET_FEAT))
                cmd = io_out;
            n = 0;
        end else if (ale) begin
            fa = (io_out == 8'h01) ? 2'd0 : (io_out == 8'h80) ? 2'd1 :
                 (io_out == 8'h81) ? 2'd2 : 2'd3;
            n = 0;
            if (cmd == CMD_GET_FEAT) ->arm;
        end else if (cmd == CMD_SET_FEAT) begin
            if (n == 0) feat[fa] = io_out & msk[fa];
            n = n + 1;
            if (n == 4) ->arm;
        end
    end
    // Busy interval; the pin tracks the ready bit
    always begin
        @(arm);
        rdy = 1'b0;
        #FEAT_NS rdy = 1'b1;
    end
    assign rb_n = rdy;
    // Step through the subfeature bytes in order
    always @(posedge re_n) if (!ce_n && (cmd == CMD_GET_FEAT || cmd == CMD_READ_MODE)) n = n + 1;
    // Single die: status or parameter; changes show while strobed low
    always @* begin
        if (cmd == CMD_STATUS || cmd == CMD_STATUS_SEL)
            val = {wp_n, rdy, rdy, 5'h00};
        else
            val = (n == 0) ? feat[fa] : 8'h00;
    end
    // Released bus shows the inverse of its last value, never a stale copy
    always @* if (!ce_n && !re_n) last = val;
    assign drive = (!ce_n && !re_n) ? val : ~last;
    assign io_in = io_oe ? io_out : drive;
endmodule // nfh_flash_model
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import nfh_pkg::*;
    logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 8'h00, io_out, io_in, fa [3], fv [3];
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic ce_n, cle, ale, we_n, re_n, wp_n, io_oe, rb_n, err;
    int miscompares = 0, comparisons = 0;
    always #20 ref_clk = ~ref_clk;
    nfh_ctrl dut (.REF_CLK(ref_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .NAND_CE_N(ce_n), .NAND_CLE(cle), .NAND_ALE(ale),
        .NAND_WE_N(we_n), .NAND_RE_N(re_n), .NAND_WP_N(wp_n), .NAND_IO_OUT(io_out),
        .NAND_IO_OE(io_oe), .NAND_IO_IN(io_in), .NAND_RB_N(rb_n));
    nfh_flash_model u_flash (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
        .wp_n(wp_n), .io_out(io_out), .io_oe(io_oe), .io_in(io_in), .rb_n(rb_n));
    // One APB transfer, held until the slave answers
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Launch an operation and poll until the busy flag drops
    task automatic run(input logic [1:0] op);
        int k;
        apb(1, REG_CMD, {30'h0, op});
        k = 0;
        do begin apb(0, REG_STAT, 0); k++; end while (rd[STAT_BUSY_BIT] !== 1'b0 && k < 500);
        if (k >= 500) chk("busy", 1, 0);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #2ms miscompares++;
        tally_and_finish;
    end
    initial begin
        fa = '{8'h01, 8'h80, 8'h81};
        fv = '{8'h05, 8'h03, 8'h02};
        repeat (2) @(posedge ref_clk);
        resetn <= 1;
        apb(0, REG_PARAM, 0); chk("param_rst", rd, 0);
        apb(0, 8'h20, 0); chk("unmapped_err", err, 1); chk("unmapped", rd, 0);
        // Power-on feature values, then write and read back with masked bits
        for (int i = 0; i < 3; i++) begin
            apb(1, REG_CFG, {22'h0, 2'b10, fa[i]});
            run(2'd0); apb(0, REG_PARAM, 0); chk("feat_dflt", rd, 0);
            apb(1, REG_PARAM, {24'hFFFFFF, 8'hF8 | fv[i]});
            run(2'd1); apb(1, REG_PARAM, 0);
            run(2'd0); apb(0, REG_PARAM, 0); chk("feat_val", rd, {24'h0, fv[i]});
        end
        // Status byte with write protect released, applied, and via addressed command
        apb(1, REG_CFG, 32'h200); run(2'd2); apb(0, REG_STAT, 0);
        chk("status_wp_off", rd[15:8], 8'hE0);
        apb(1, REG_CFG, 32'h000); run(2'd2); apb(0, REG_STAT, 0);
        chk("status_wp_on", rd[15:8], 8'h60);
        apb(1, REG_ROW, 32'h010203); apb(1, REG_CFG, 32'h300); run(2'd2); apb(0, REG_STAT, 0);
        chk("status_sel", rd[15:8], 8'hE0);
        chk("rb_pin", rd[STAT_RB_BIT], 1);
        apb(0, REG_ROW, 0); chk("row_back", rd, 32'h0001_0203);
        apb(0, REG_CMD, 0); chk("last_op", rd, 2);
        // Illegal op code and a command while busy are both refused
        apb(1, REG_CMD, 3); apb(0, REG_STAT, 0); chk("refuse_op", rd[STAT_REFUSE_BIT], 1);
        apb(1, REG_STAT, 2); apb(0, REG_STAT, 0); chk("refuse_clr", rd[STAT_REFUSE_BIT], 0);
        apb(1, REG_CMD, 2); apb(1, REG_CMD, 2); apb(0, REG_STAT, 0);
        chk("refuse_while_busy", rd[1:0], 2'b11);
        run(2'd3);
        chk("refuse_busy", rd[STAT_REFUSE_BIT], 1);
        tally_and_finish;
    end
endmodule // tb
`default_nettype wire
